/* src/sleep_wake_pkg.sv */
// Constants, register map and types for the sleep, watchdog and wake control
package sleep_wake_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned OSC_HZ = 10_000;
   localparam int unsigned TICK_CYC = CLK_HZ / OSC_HZ;
   localparam int unsigned PRE_DIV = 64;
   localparam int unsigned RTC_PERIOD_US = 12_800;
   localparam int unsigned RTC_TICKS = RTC_PERIOD_US * (OSC_HZ / 1000) / 1000;
   localparam logic [2:0] WD_LIMIT = 3'h4;
   localparam logic [12:0] USER_ADDR = 13'h0030;
   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_CFG0 = 8'h00;
   localparam logic [7:0] IDX_CFG1 = 8'h01;
   localparam logic [7:0] IDX_STATUS = 8'hF6;
   localparam logic [7:0] IDX_TIMER = 8'hFE;
   // ************************************************************
   // Fields
   // ************************************************************
   localparam int unsigned CONV_LSB = 16;
   localparam int unsigned SLEEP_BIT = 17;
   localparam int unsigned PWR_PRG_BIT = 0;
   localparam int unsigned USR_PRG_BIT = 1;
   localparam int unsigned SINGLE_BIT = 2;
   localparam int unsigned AVG_LSB = 4;
   localparam int unsigned ST_ENDMEAS_BIT = 16;
   localparam int unsigned ST_WDT_BIT = 17;
   localparam int unsigned ST_BTN_BIT = 18;
   localparam int unsigned ST_WAKE_BIT = 22;
   localparam logic [7:0] CONV_RST = 8'h01;
   localparam logic [3:0] AVG_RST = 4'h1;
   typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_RUN} seq_state_t;
endpackage

/* src/tick_if.sv */
// Slow-rate enable pulses shared between the divider and the controller
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
   logic tick_10k;
   logic tick_rtc;
   modport src (output tick_10k, output tick_rtc);
   modport snk (input tick_10k, input tick_rtc);
endinterface
`default_nettype wire

/* src/tick_divider.sv */
// Divider making the 10 kHz and real-time enable pulses from the main clock
`timescale 1ns/1ns
`default_nettype none
module tick_divider
   import sleep_wake_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic restart,
   tick_if.src ticks
);
   logic [10:0] div_q;
   logic [6:0] rtc_div_q;
   logic tick_d;
   logic rtc_d;
   assign tick_d = (div_q == 11'(TICK_CYC - 1));
   assign rtc_d = tick_d && (rtc_div_q == 7'(RTC_TICKS - 1));
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_q <= 11'h000;
         rtc_div_q <= 7'h00;
         ticks.tick_10k <= 1'b0;
         ticks.tick_rtc <= 1'b0;
      end
      else
      begin
         div_q <= (tick_d || restart) ? 11'h000 : div_q + 11'h001;
         if (restart)
            rtc_div_q <= 7'h00;
         else if (tick_d)
            rtc_div_q <= rtc_d ? 7'h00 : rtc_div_q + 7'h01;
         ticks.tick_10k <= tick_d && !restart;
         ticks.tick_rtc <= rtc_d && !restart;
      end
   end
endmodule
`default_nettype wire

/* src/sleep_watchdog_wake_control.sv */
// Reset, sleep, conversion counter, watchdog and real-time counter control
`timescale 1ns/1ns
`default_nettype none
module sleep_watchdog_wake_control
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [9:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SELECT_RESET_PIN,
   input wire logic MODE_FLOAT,
   input wire logic WDOG_OFF_CMD,
   input wire logic MEAS_DONE,
   input wire logic CPU_CLR_WDT,
   input wire logic CPU_DONE,
   output logic MEAS_START,
   output logic CPU_START,
   output logic [12:0] CPU_ADDR,
   output logic CHIP_RST,
   output logic CLK_RUN,
   output logic [3:0] AVG_RATE,
   output logic WDOG_ON
);
   import sleep_wake_pkg::*;

   // ************************************************************
   // Pin synchronisers and slow ticks
   // ************************************************************
   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_q;
   logic pin_prev_q;
   logic pin_edge;
   logic btn_press;
   logic standalone;
   tick_if ticks ();

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pin_meta_q <= 2'h3;
         pin_sync_q <= 2'h3;
         pin_prev_q <= 1'b1;
      end
      else
      begin
         pin_meta_q <= {MODE_FLOAT, SELECT_RESET_PIN};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q[0];
      end
   end

   assign standalone = pin_sync_q[1];
   assign pin_edge = pin_sync_q[0] ^ pin_prev_q;
   assign btn_press = standalone && pin_prev_q && !pin_sync_q[0];

   // ************************************************************
   // Register file over APB
   // ************************************************************
   logic [7:0] conv_q;
   logic sleep_q;
   logic pwr_prg_q;
   logic usr_prg_q;
   logic single_q;
   logic [3:0] avg_q;
   logic [23:0] timer_q;
   logic [23:0] status;
   logic [7:0] reg_idx;
   logic addr_ok;
   logic wr_en;
   logic [31:0] rd_mux;

   assign reg_idx = PADDR[9:2];
   assign addr_ok = (PADDR[1:0] == 2'h0) && (reg_idx == IDX_CFG0 || reg_idx == IDX_CFG1
                    || reg_idx == IDX_STATUS || reg_idx == IDX_TIMER);
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE && addr_ok;
   assign rd_mux = (reg_idx == IDX_CFG0) ? {8'h00, conv_q, 16'h0000} :
                   (reg_idx == IDX_CFG1) ? {14'h0000, sleep_q, 9'h000, avg_q, 1'b0,
                                            single_q, usr_prg_q, pwr_prg_q} :
                   (reg_idx == IDX_STATUS) ? {8'h00, status} :
                   (reg_idx == IDX_TIMER) ? {8'h00, timer_q} : 32'h0000_0000;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end
      else
      begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !addr_ok;
         if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= addr_ok ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         conv_q <= CONV_RST;
         sleep_q <= 1'b0;
         pwr_prg_q <= 1'b0;
         usr_prg_q <= 1'b0;
         single_q <= 1'b0;
         avg_q <= AVG_RST;
      end
      else if (wr_en && reg_idx == IDX_CFG0)
         conv_q <= PWDATA[CONV_LSB +: 8];
      else if (wr_en && reg_idx == IDX_CFG1)
      begin
         sleep_q <= PWDATA[SLEEP_BIT];
         pwr_prg_q <= PWDATA[PWR_PRG_BIT];
         usr_prg_q <= PWDATA[USR_PRG_BIT];
         single_q <= PWDATA[SINGLE_BIT];
         avg_q <= PWDATA[AVG_LSB +: 4];
      end
   end

   // ************************************************************
   // Conversion counter
   // ************************************************************
   // An interval of zero gives 256 periods rather than a stuck counter.
   logic [5:0] pre_q;
   logic [7:0] int_q;
   logic pre_wrap;
   logic conv_end;
   logic chip_rst_evt;

   assign pre_wrap = ticks.tick_10k && (pre_q == 6'(PRE_DIV - 1));
   assign conv_end = pre_wrap && (int_q == conv_q - 8'h01);

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pre_q <= 6'h00;
         int_q <= 8'h00;
      end
      else if (chip_rst_evt)
      begin
         pre_q <= 6'h00;
         int_q <= 8'h00;
      end
      else if (ticks.tick_10k)
      begin
         pre_q <= pre_q + 6'h01;
         if (pre_wrap)
            int_q <= conv_end ? 8'h00 : int_q + 8'h01;
      end
   end

   // ************************************************************
   // Real-time counter
   // ************************************************************
   logic [23:0] rtc_q;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
         rtc_q <= 24'h000000;
      else if (chip_rst_evt)
         rtc_q <= 24'h000000;
      else if (ticks.tick_rtc)
         rtc_q <= rtc_q + 24'h000001;
   end

   tick_divider u_div
   (
      .clk(MCLK),
      .rst_b(RST_B),
      .restart(chip_rst_evt),
      .ticks(ticks.src)
   );

   // ************************************************************
   // Watchdog
   // ************************************************************
   // Sleep wake-ups also count, so a hung user code in sleep still trips.
   logic [2:0] wd_q;
   logic wd_trip;
   logic meas_go;
   logic wake_go;

   // Held off while the reset pulse stands, so one trip gives exactly one pulse.
   assign wd_trip = WDOG_ON && (wd_q == WD_LIMIT) && !CHIP_RST;
   assign chip_rst_evt = CHIP_RST;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wd_q <= 3'h0;
         WDOG_ON <= 1'b1;
         CHIP_RST <= 1'b0;
      end
      else
      begin
         CHIP_RST <= wd_trip || btn_press;
         if (WDOG_OFF_CMD && !standalone)
            WDOG_ON <= 1'b0;
         if (CHIP_RST || CPU_CLR_WDT || pin_edge)
            wd_q <= 3'h0;
         else if ((meas_go || wake_go) && wd_q != WD_LIMIT)
            wd_q <= wd_q + 3'h1;
      end
   end

   // ************************************************************
   // Start sequencer and status flags
   // ************************************************************
   seq_state_t state_q;
   logic flg_wake_q;
   logic flg_btn_q;
   logic flg_wdt_q;
   logic flg_end_q;
   logic done_ok;

   assign meas_go = conv_end && !sleep_q && !CHIP_RST;
   assign wake_go = conv_end && sleep_q && !CHIP_RST && usr_prg_q;
   assign done_ok = MEAS_DONE && state_q == ST_MEAS && !CHIP_RST && !conv_end;
   assign status = {1'b0, flg_wake_q, 3'h0, flg_btn_q, flg_wdt_q, flg_end_q, 16'h0000};

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_q <= ST_IDLE;
         MEAS_START <= 1'b0;
         CPU_START <= 1'b0;
         CPU_ADDR <= 13'h0000;
         timer_q <= 24'h000000;
      end
      else
      begin
         MEAS_START <= meas_go;
         CPU_START <= 1'b0;
         if (CHIP_RST)
         begin
            state_q <= pwr_prg_q ? ST_RUN : ST_IDLE;
            CPU_START <= pwr_prg_q;
            CPU_ADDR <= USER_ADDR;
         end
         else if (meas_go)
            state_q <= ST_MEAS;
         else if (wake_go)
         begin
            state_q <= ST_RUN;
            CPU_START <= 1'b1;
            CPU_ADDR <= USER_ADDR;
         end
         else if (done_ok)
         begin
            timer_q <= rtc_q;
            state_q <= usr_prg_q ? ST_RUN : ST_IDLE;
            CPU_START <= usr_prg_q;
            CPU_ADDR <= USER_ADDR;
         end
         else if (CPU_DONE && state_q == ST_RUN)
            state_q <= ST_IDLE;
      end
   end

   // Flags clear when the processor stops; a new cause in that cycle wins.
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         flg_wake_q <= 1'b0;
         flg_btn_q <= 1'b0;
         flg_wdt_q <= 1'b0;
         flg_end_q <= 1'b0;
      end
      else
      begin
         flg_wake_q <= wake_go || (flg_wake_q && !CPU_DONE);
         flg_btn_q <= btn_press || (flg_btn_q && !CPU_DONE);
         flg_wdt_q <= wd_trip || (flg_wdt_q && !CPU_DONE);
         flg_end_q <= done_ok || (flg_end_q && !CPU_DONE);
      end
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         CLK_RUN <= 1'b1;
         AVG_RATE <= AVG_RST;
      end
      else
      begin
         CLK_RUN <= !(sleep_q && state_q == ST_IDLE);
         AVG_RATE <= sleep_q ? 4'h0 : avg_q;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   sequence s_trip;
      WDOG_ON && wd_q == WD_LIMIT && !CHIP_RST;
   endsequence
   sequence s_reset_start;
      CHIP_RST ##1 (CPU_START == $past(pwr_prg_q) && CPU_ADDR == USER_ADDR);
   endsequence

   property p_wd_trip;
      s_trip |=> flg_wdt_q ##0 s_reset_start;
   endproperty
   a_wd_trip: assert property (p_wd_trip) else $error("watchdog trip not handled");
   property p_btn;
      btn_press |=> CHIP_RST && flg_btn_q;
   endproperty
   a_btn: assert property (p_btn) else $error("button reset not reported");
   property p_start_addr;
      CPU_START |-> CPU_ADDR == USER_ADDR;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("user code not at 48");
   property p_sleep_clk;
      sleep_q && state_q == ST_IDLE |=> !CLK_RUN;
   endproperty
   a_sleep_clk: assert property (p_sleep_clk) else $error("clocks run in sleep");
   property p_sleep_nomeas;
      sleep_q && conv_end |=> !MEAS_START;
   endproperty
   a_sleep_nomeas: assert property (p_sleep_nomeas) else $error("measured in sleep");
   property p_wake_flag;
      wake_go |=> CPU_START && flg_wake_q && status[ST_WAKE_BIT];
   endproperty
   a_wake_flag: assert property (p_wake_flag) else $error("wake flag missing");
   property p_avg;
      sleep_q |=> AVG_RATE == 4'h0;
   endproperty
   a_avg: assert property (p_avg) else $error("avg rate not zero");
   property p_wd_inc;
      meas_go && !pin_edge && !CPU_CLR_WDT && wd_q < WD_LIMIT |=> wd_q == $past(wd_q) + 3'h1;
   endproperty
   a_wd_inc: assert property (p_wd_inc) else $error("watchdog not counted");
   property p_edge_clr;
      pin_edge |=> wd_q == 3'h0;
   endproperty
   a_edge_clr: assert property (p_edge_clr) else $error("edge did not clear");
   property p_timer;
      done_ok |=> timer_q == $past(rtc_q);
   endproperty
   a_timer: assert property (p_timer) else $error("timer not captured");
   property p_cfg0;
      wr_en && reg_idx == IDX_CFG0 |=> conv_q == $past(PWDATA[23:16]);
   endproperty
   a_cfg0: assert property (p_cfg0) else $error("interval not written");
endmodule
`default_nettype wire

/* verification/meas_cpu_model.sv */
// Behavioural model of the measurement unit and processor core beside the block
`timescale 1ns/1ns
`default_nettype none
module meas_cpu_model
(
   input wire logic clk,
   input wire logic meas_start,
   input wire logic cpu_start,
   output logic meas_done,
   output logic cpu_clr_wdt,
   output logic cpu_done
);
   int meas_lat = 40;
   int run_lat = 20;
   initial
   begin
      meas_done = 1'b0;
      cpu_clr_wdt = 1'b0;
      cpu_done = 1'b0;
   end
   // ***********************************************
   // Measurement and user code
   // ***********************************************
   always @(posedge clk)
   begin
      if (meas_start === 1'b1)
      begin
         repeat (meas_lat) @(posedge clk);
         meas_done <= 1'b1;
         @(posedge clk);
         meas_done <= 1'b0;
      end
   end
   // User code clears the watchdog, then stops; the flags stay readable until then
   always @(posedge clk)
   begin
      if (cpu_start === 1'b1)
      begin
         repeat (run_lat) @(posedge clk);
         cpu_clr_wdt <= 1'b1;
         @(posedge clk);
         cpu_clr_wdt <= 1'b0;
         cpu_done <= 1'b1;
         @(posedge clk);
         cpu_done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* verification/tb_sleep_watchdog_wake_control.sv */
// Self-checking bench for the sleep, watchdog and wake control block
`timescale 1ns/1ns
`default_nettype none
module tb_sleep_watchdog_wake_control;
   import sleep_wake_pkg::*;
   localparam logic [9:0] A_CFG0 = {IDX_CFG0, 2'b00};
   localparam logic [9:0] A_CFG1 = {IDX_CFG1, 2'b00};
   localparam logic [9:0] A_STAT = {IDX_STATUS, 2'b00};
   localparam logic [9:0] A_TMR = {IDX_TIMER, 2'b00};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic pin = 1'b1;
   logic mode_float = 1'b1;
   logic wdog_off = 1'b0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [12:0] cpu_addr;
   logic [3:0] avg_rate;
   logic pready, pslverr, meas_done, cpu_clr_wdt, cpu_done, meas_start, cpu_start;
   logic chip_rst, clk_run, wdog_on, err;
   int n_fail = 0;
   int total_checks = 0;
   longint cyc = 0;
   longint t_rst = 0;
   sleep_watchdog_wake_control sleep_watchdog_wake_control_i (.MCLK(mclk), .RST_B(rst_b),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SELECT_RESET_PIN(pin),
      .MODE_FLOAT(mode_float), .WDOG_OFF_CMD(wdog_off), .MEAS_DONE(meas_done),
      .CPU_CLR_WDT(cpu_clr_wdt), .CPU_DONE(cpu_done), .MEAS_START(meas_start),
      .CPU_START(cpu_start), .CPU_ADDR(cpu_addr), .CHIP_RST(chip_rst), .CLK_RUN(clk_run),
      .AVG_RATE(avg_rate), .WDOG_ON(wdog_on));
   meas_cpu_model meas_cpu_model_i (.clk(mclk), .meas_start(meas_start),
      .cpu_start(cpu_start), .meas_done(meas_done), .cpu_clr_wdt(cpu_clr_wdt),
      .cpu_done(cpu_done));
   initial
   begin
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;
   // ***********************************************
   // Shared tasks
   // ***********************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1);
      // Zero wait states: ready must come in the first access cycle
      chk(n, 32'd1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_regs();
      apb(1'b0, A_CFG0, 32'h0);
      chk(rd, {8'h00, CONV_RST, 16'h0000});
      chk(err, 1'b0);
      apb(1'b0, A_CFG1, 32'h0);
      chk(rd, {24'h000000, AVG_RST, 4'h0});
      apb(1'b0, A_STAT, 32'h0);
      chk(rd, 32'h00000000);
      apb(1'b1, A_TMR, 32'h00ABCDEF);
      apb(1'b0, A_TMR, 32'h0);
      chk(rd, 32'h00000000);
      apb(1'b0, 10'h100, 32'h0);
      chk(err, 1'b1);
      apb(1'b0, 10'h002, 32'h0);
      chk(err, 1'b1);
      chk(wdog_on, 1'b1);
      chk(clk_run, 1'b1);
      $display("test regs done");
   endtask
   // Single-shot goes with sleep, as the host must do
   task automatic t_sleep_cfg();
      apb(1'b1, A_CFG1, 32'h00020054);
      apb(1'b0, A_CFG1, 32'h0);
      chk(rd, 32'h00020054);
      chk(avg_rate, 4'h0);
      chk(clk_run, 1'b0);
      apb(1'b1, A_CFG1, 32'h00000050);
      apb(1'b1, A_CFG0, 32'h00250000);
      apb(1'b0, A_CFG0, 32'h0);
      chk(rd, 32'h00250000);
      chk(avg_rate, 4'h5);
      apb(1'b1, A_CFG0, 32'h00010000);
      wdog_off <= 1'b1;
      @(posedge mclk);
      wdog_off <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(wdog_on, 1'b1);
      $display("test sleep config done");
   endtask
   task automatic t_button();
      apb(1'b1, A_CFG1, 32'h00000053);
      pin <= 1'b0;
      wait_hi(chip_rst, 12);
      chk(chip_rst, 1'b1);
      t_rst = cyc;
      @(posedge mclk);
      chk(cpu_start, 1'b1);
      chk(cpu_addr, USER_ADDR);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd, 32'h00040000);
      pin <= 1'b1;
      repeat (40) @(posedge mclk);
      apb(1'b0, A_CFG1, 32'h0);
      chk(rd, 32'h00000053);
      $display("test button done");
   endtask
   // First conversion after the button restart, one interval of one
   task automatic t_conv();
      longint d;
      wait_hi(meas_start, 140000);
      d = cyc - t_rst;
      chk((d > PRE_DIV * TICK_CYC - 9) && (d < PRE_DIV * TICK_CYC + 9), 1'b1);
      @(posedge mclk);
      chk(meas_start, 1'b0);
      wait_hi(cpu_start, 100);
      chk(cpu_start, 1'b1);
      chk(cpu_addr, USER_ADDR);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd, 32'h00010000);
      apb(1'b0, A_TMR, 32'h0);
      chk(rd, 32'h00000000);
      $display("test conversion done");
   endtask
   task automatic t_spi();
      mode_float <= 1'b0;
      repeat (6) @(posedge mclk);
      pin <= 1'b0;
      wait_hi(chip_rst, 12);
      chk(chip_rst, 1'b0);
      pin <= 1'b1;
      wdog_off <= 1'b1;
      @(posedge mclk);
      wdog_off <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(wdog_on, 1'b0);
      $display("test spi mode done");
   endtask
   initial
   begin
      #12000000;
      n_fail++;
      end_of_test();
   end
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      t_regs();
      t_sleep_cfg();
      t_button();
      t_conv();
      t_spi();
      end_of_test();
   end
endmodule
`default_nettype wire
